// *** inc/bda_defs.svh ***
// constants for the decimal adjust and decrement datapath
`ifndef BDA_DEFS_SVH
`define BDA_DEFS_SVH

`define BDA_OFS_CMD 8'h00
`define BDA_OFS_WREG 8'h04
`define BDA_OFS_STATUS 8'h08
`define BDA_OFS_BANK 8'h0c
`define BDA_OFS_FADDR 8'h10
`define BDA_OFS_FDATA 8'h14
`define BDA_OFS_CYCLES 8'h18

`define BDA_CMD_W 13
`define BDA_STAT_BUSY_BIT 8
`define BDA_STAT_SKIP_BIT 9

`define BDA_RST_W 8'h00
`define BDA_RST_FLAGS 5'h00
`define BDA_RST_BANK 4'h0
`define BDA_RST_FADDR 12'h000

`define BDA_BCD_MAX 4'h9
`define BDA_ADJ_LO 9'h006
`define BDA_ADJ_HI 9'h060
`define BDA_ACC_SPLIT 8'h80
`define BDA_ACC_LO_BANK 4'h0
`define BDA_ACC_HI_BANK 4'hf
`define BDA_OVFL_EDGE 8'h80

`define BDA_CLK_NS 10
`define BDA_TCY_NS 40
`define BDA_Q_PER_CYC (`BDA_TCY_NS / `BDA_CLK_NS)
`define BDA_FILE_WORDS 4096

`endif

// *** inc/bda_pkg.sv ***
// types for the decimal adjust and decrement datapath
`default_nettype none
package bda_pkg;
  typedef enum logic [1:0] {
    bda_decimal_adjust_op = 2'h0,
    bda_decrement_op = 2'h1,
    bda_decrement_skip_zero_op = 2'h2,
    bda_decrement_skip_nonzero_op = 2'h3
  } bda_op_t;

  typedef enum logic [2:0] {
    bda_st_idle = 3'b001,
    bda_st_exec = 3'b010,
    bda_st_flush = 3'b100
  } bda_state_t;

  typedef struct packed {
    logic two_word;
    bda_op_t op;
    logic dest;
    logic bank_sel;
    logic [7:0] faddr;
  } bda_cmd_t;

  typedef struct packed {
    logic negative_flag;
    logic overflow_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } bda_flags_t;
endpackage
`default_nettype wire

// *** verif/bda_ahb_master.sv ***
// ahb-lite master model driving the register slave
`default_nettype none
module bda_ahb_master (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one single word transfer, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    haddr <= ~{24'h0, a};
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // released data lines must not keep the last value
    hwdata <= ~hwdata;
  endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the decimal adjust and decrement datapath
`include "bda_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import bda_pkg::*;
  typedef struct packed {
    bda_op_t op;
    logic [2:0] dat;
    logic [7:0] f;
    logic [7:0] m;
    logic [7:0] r;
    logic [4:0] fl;
    logic sk;
    logic [1:0] cyc;
  } bda_tc_t;
  localparam int QC = `BDA_Q_PER_CYC;
  localparam bda_op_t K_D = bda_decrement_op;
  localparam bda_op_t K_Z = bda_decrement_skip_zero_op;
  localparam bda_op_t K_N = bda_decrement_skip_nonzero_op;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, busy, idle_op;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  bda_cmd_t c0;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_cyc = 0;
  // w in, flags in, w out, flags out
  logic [25:0] da [5] = '{{8'ha5, 5'h00, 8'h05, 5'h01},
    {8'hce, 5'h00, 8'h34, 5'h01}, {8'h28, 5'h02, 8'h2e, 5'h02},
    {8'h42, 5'h15, 8'ha2, 5'h15}, {8'h99, 5'h0c, 8'h99, 5'h0c}};
  // op, {dest, bank, two word}, f, mem, result, flags, skip, cycles
  bda_tc_t tcs [9] = '{
    '{K_D, 3'h6, 8'h45, 8'h01, 8'h00, 5'h07, 1'b0, 2'h1},
    '{K_D, 3'h0, 8'h90, 8'h80, 8'h7f, 5'h09, 1'b0, 2'h1},
    '{K_D, 3'h4, 8'h10, 8'h00, 8'hff, 5'h10, 1'b0, 2'h1},
    '{K_Z, 3'h6, 8'h20, 8'h01, 8'h00, 5'h0a, 1'b1, 2'h2},
    '{K_Z, 3'h7, 8'h20, 8'h01, 8'h00, 5'h0a, 1'b1, 2'h3},
    '{K_Z, 3'h2, 8'h20, 8'h05, 8'h04, 5'h0a, 1'b0, 2'h1},
    '{K_N, 3'h0, 8'h30, 8'h05, 8'h04, 5'h0a, 1'b1, 2'h2},
    '{K_N, 3'h7, 8'h21, 8'h01, 8'h00, 5'h0a, 1'b0, 2'h1},
    '{K_N, 3'h5, 8'hf0, 8'h03, 8'h02, 5'h0a, 1'b1, 2'h3}};

  always #5 hclk = ~hclk;

  bda_alu #(.Q_PER_CYC(QC), .FILE_WORDS(`BDA_FILE_WORDS)) u_bda_alu (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .busy(busy), .idle_op(idle_op));

  bda_ahb_master u_bda_ahb_master (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_bda_ahb_master.xfer(1'b1, a, d, rd);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    u_bda_ahb_master.xfer(1'b0, a, 32'h0, rd);
    check(rd, exp);
    check({30'h0, hreadyout, hresp}, 32'h2);
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // issue one instruction and count its busy and idle clocks
  task automatic run(input bda_cmd_t c, input int cyc);
    int nb;
    int ni;
    nb = 0;
    ni = 0;
    wr(`BDA_OFS_CMD, {19'h0, c});
    repeat (3 * QC + 2) begin
      @(posedge hclk);
      nb += int'(busy === 1'b1);
      ni += int'(idle_op === 1'b1);
    end
    check(32'(nb), 32'(cyc * QC));
    check(32'(ni), 32'((cyc - 1) * QC));
    rchk(`BDA_OFS_CYCLES, 32'(cyc));
  endtask

  task automatic dec(input bda_tc_t t);
    logic [11:0] pa;
    bda_cmd_t c;
    pa = t.dat[1] ? {4'h3, t.f} : {(t.f[7] ? 4'hf : 4'h0), t.f};
    c = '{two_word: t.dat[0], op: t.op, dest: t.dat[2],
      bank_sel: t.dat[1], faddr: t.f};
    wr(`BDA_OFS_BANK, 32'h3);
    wr(`BDA_OFS_WREG, 32'h5a);
    wr(`BDA_OFS_STATUS, 32'h0a);
    wr(`BDA_OFS_FADDR, {20'h0, pa});
    wr(`BDA_OFS_FDATA, {24'h0, t.m});
    run(c, int'(t.cyc));
    rchk(`BDA_OFS_WREG, {24'h0, t.dat[2] ? 8'h5a : t.r});
    rchk(`BDA_OFS_FDATA, {24'h0, t.dat[2] ? t.r : t.m});
    rchk(`BDA_OFS_STATUS, {22'h0, t.sk, 4'h0, t.fl});
  endtask

  always @(posedge hclk) begin
    n_cyc++;
    if (n_cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wr(`BDA_OFS_FDATA, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rchk(8'(i * 4), 32'h0);
    end
    wr(8'h1c, 32'h5555_aaaa);
    rchk(8'h1c, 32'h0);
    wr(`BDA_OFS_BANK, 32'hffff_ffff);
    rchk(`BDA_OFS_BANK, 32'hf);
    $display("test registers done");
    c0 = '{two_word: 1'b0, op: bda_decimal_adjust_op, dest: 1'b0,
      bank_sel: 1'b0, faddr: 8'h00};
    for (int i = 0; i < 5; i++) begin
      wr(`BDA_OFS_WREG, {24'h0, da[i][25:18]});
      wr(`BDA_OFS_STATUS, {27'h0, da[i][17:13]});
      run(c0, 1);
      rchk(`BDA_OFS_WREG, {24'h0, da[i][12:5]});
      rchk(`BDA_OFS_STATUS, {27'h0, da[i][4:0]});
    end
    $display("test decimal adjust done");
    for (int i = 0; i < 9; i++) begin
      dec(tcs[i]);
    end
    $display("test decrements done");
    c0 = '{two_word: 1'b0, op: bda_decrement_op, dest: 1'b1,
      bank_sel: 1'b1, faddr: 8'h45};
    wr(`BDA_OFS_WREG, 32'h11);
    wr(`BDA_OFS_CMD, {19'h0, c0});
    wr(`BDA_OFS_WREG, 32'hee);
    u_bda_ahb_master.xfer(1'b0, `BDA_OFS_STATUS, 32'h0, rd);
    check({31'h0, rd[8]}, 32'h1);
    repeat (2 * QC) @(posedge hclk);
    rchk(`BDA_OFS_WREG, 32'h11);
    $display("test busy refusal done");
    print_verdict();
  end
endmodule
`default_nettype wire

// *** verilog/bda_alu.sv ***
// datapath top with ahb-lite register slave and file register memory
`include "bda_defs.svh"
`default_nettype none
module bda_alu #(
  parameter int Q_PER_CYC = `BDA_Q_PER_CYC,
  parameter int FILE_WORDS = `BDA_FILE_WORDS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic busy,
  output logic idle_op
);
  import bda_pkg::*;

  localparam logic [7:0] QLAST = 8'(Q_PER_CYC - 1);

  // ahb address phase capture
  logic ap_valid, next_ap_valid;
  logic ap_write, next_ap_write;
  logic [7:0] ap_ofs, next_ap_ofs;

  // core state
  bda_state_t state, next_state;
  logic [7:0] qcnt, next_qcnt;
  logic [1:0] flush_left, next_flush_left;
  bda_cmd_t cur, next_cur;
  logic [7:0] w_reg, next_w_reg;
  bda_flags_t flags, next_flags;
  logic [3:0] bank_select_reg, next_bank_select_reg;
  logic [11:0] faddr, next_faddr;
  logic [1:0] cycles_last, next_cycles_last;
  logic skip_last, next_skip_last;
  logic [31:0] next_hrdata;
  logic next_busy, next_idle_op;

  logic [7:0] file_mem [FILE_WORDS];
  logic mem_we;
  logic [11:0] mem_wa;
  logic [7:0] mem_wd;

  logic wr_en;
  logic [11:0] op_addr;
  logic [7:0] fval;
  logic [7:0] res;
  bda_flags_t res_flags;
  logic res_skip;
  logic last_q;

  function automatic logic [11:0] bank_addr(input logic a,
                                            input logic [7:0] f,
                                            input logic [3:0] bank);
    if (!a) begin
      bank_addr = (f < `BDA_ACC_SPLIT) ? {`BDA_ACC_LO_BANK, f}
                                       : {`BDA_ACC_HI_BANK, f};
    end else begin
      bank_addr = {bank, f};
    end
  endfunction

  function automatic logic [7:0] mem_rd(input logic [11:0] a);
    if (32'(a) < FILE_WORDS) begin
      mem_rd = file_mem[a];
    end else begin
      mem_rd = 8'h00;
    end
  endfunction

  always_comb begin
    next_ap_valid = hsel & hready & htrans[1];
    next_ap_write = hwrite;
    next_ap_ofs = haddr[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_ofs <= 8'h00;
    end else begin
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_ofs <= next_ap_ofs;
    end
  end

  assign wr_en = ap_valid & ap_write;
  assign last_q = (qcnt == QLAST);
  assign op_addr = bank_addr(cur.bank_sel, cur.faddr, bank_select_reg);
  always_comb begin
    fval = (cur.op == bda_decimal_adjust_op) ? w_reg : mem_rd(op_addr);
  end

  bda_dec_unit u_dec (
    .op(cur.op),
    .acc(w_reg),
    .fval(fval),
    .flags_in(flags),
    .flags_out(res_flags),
    .result(res),
    .skip(res_skip)
  );

  always_comb begin
    next_state = state;
    next_qcnt = qcnt;
    next_flush_left = flush_left;
    next_cur = cur;
    next_w_reg = w_reg;
    next_flags = flags;
    next_bank_select_reg = bank_select_reg;
    next_faddr = faddr;
    next_cycles_last = cycles_last;
    next_skip_last = skip_last;
    mem_we = 1'b0;
    mem_wa = faddr;
    mem_wd = hwdata[7:0];
    unique case (state)
      bda_st_idle: begin
        if (wr_en) begin
          unique case (ap_ofs)
            `BDA_OFS_CMD: begin
              next_cur = bda_cmd_t'(hwdata[`BDA_CMD_W-1:0]);
              next_state = bda_st_exec;
              next_qcnt = 8'h00;
            end
            `BDA_OFS_WREG: next_w_reg = hwdata[7:0];
            `BDA_OFS_STATUS: next_flags = bda_flags_t'(hwdata[4:0]);
            `BDA_OFS_BANK: next_bank_select_reg = hwdata[3:0];
            `BDA_OFS_FADDR: next_faddr = hwdata[11:0];
            `BDA_OFS_FDATA: mem_we = (32'(faddr) < FILE_WORDS);
            default: begin
            end
          endcase
        end
      end
      bda_st_exec: begin
        next_qcnt = qcnt + 8'h01;
        if (last_q) begin
          next_qcnt = 8'h00;
          next_flags = res_flags;
          next_skip_last = res_skip;
          next_cycles_last = 2'd1;
          next_state = bda_st_idle;
          if (cur.op == bda_decimal_adjust_op || !cur.dest) begin
            next_w_reg = res;
          end else begin
            mem_we = (32'(op_addr) < FILE_WORDS);
            mem_wa = op_addr;
            mem_wd = res;
          end
          if (res_skip) begin
            next_state = bda_st_flush;
            next_flush_left = cur.two_word ? 2'd2 : 2'd1;
            next_cycles_last = cur.two_word ? 2'd3 : 2'd2;
          end
        end
      end
      bda_st_flush: begin
        next_qcnt = qcnt + 8'h01;
        if (last_q) begin
          next_qcnt = 8'h00;
          next_flush_left = flush_left - 2'd1;
          if (flush_left == 2'd1) begin
            next_state = bda_st_idle;
          end
        end
      end
    endcase
    next_busy = (next_state != bda_st_idle);
    next_idle_op = (next_state == bda_st_flush);
  end

  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (next_ap_valid && !hwrite) begin
      unique case (haddr[7:0])
        `BDA_OFS_WREG: next_hrdata = {24'h000000, next_w_reg};
        `BDA_OFS_STATUS: begin
          next_hrdata = {27'h0000000, next_flags};
          next_hrdata[`BDA_STAT_BUSY_BIT] = next_busy;
          next_hrdata[`BDA_STAT_SKIP_BIT] = next_skip_last;
        end
        `BDA_OFS_BANK: next_hrdata = {28'h0000000, next_bank_select_reg};
        `BDA_OFS_FADDR: next_hrdata = {20'h00000, next_faddr};
        `BDA_OFS_FDATA: begin
          next_hrdata = {24'h000000, mem_rd(next_faddr)};
          if (mem_we && mem_wa == next_faddr) begin
            next_hrdata = {24'h000000, mem_wd};
          end
        end
        `BDA_OFS_CYCLES: next_hrdata = {30'h00000000, next_cycles_last};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk) begin
    if (mem_we) begin
      file_mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= bda_st_idle;
      qcnt <= 8'h00;
      flush_left <= 2'd0;
      cur <= '0;
      w_reg <= `BDA_RST_W;
      flags <= `BDA_RST_FLAGS;
      bank_select_reg <= `BDA_RST_BANK;
      faddr <= `BDA_RST_FADDR;
      cycles_last <= 2'd0;
      skip_last <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      busy <= 1'b0;
      idle_op <= 1'b0;
    end else begin
      state <= next_state;
      qcnt <= next_qcnt;
      flush_left <= next_flush_left;
      cur <= next_cur;
      w_reg <= next_w_reg;
      flags <= next_flags;
      bank_select_reg <= next_bank_select_reg;
      faddr <= next_faddr;
      cycles_last <= next_cycles_last;
      skip_last <= next_skip_last;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      busy <= next_busy;
      idle_op <= next_idle_op;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic exec_end;
  assign exec_end = (state == bda_st_exec) && last_q;

  AST_ADJ_LO: assert property (
    exec_end && cur.op == bda_decimal_adjust_op &&
    (w_reg[3:0] > `BDA_BCD_MAX) |=>
    w_reg[3:0] == $past(w_reg[3:0]) + 4'h6)
    else $error("low nibble not adjusted");
  AST_ADJ_HI: assert property (
    exec_end && cur.op == bda_decimal_adjust_op &&
    (w_reg[7:4] > `BDA_BCD_MAX) |=> flags.carry_flag)
    else $error("high nibble adjust left carry clear");
  AST_DEST_W: assert property (
    exec_end && cur.op != bda_decimal_adjust_op && !cur.dest |=>
    w_reg == $past(fval) - 8'h01)
    else $error("accumulator not given decremented value");
  AST_DEST_F: assert property (
    exec_end && cur.op != bda_decimal_adjust_op && cur.dest |=>
    file_mem[$past(op_addr)] == $past(fval) - 8'h01 &&
    w_reg == $past(w_reg))
    else $error("file register not given decremented value");
  AST_SKIP_ZERO: assert property (
    exec_end && cur.op == bda_decrement_skip_zero_op &&
    fval == 8'h01 |=> state == bda_st_flush)
    else $error("zero result did not skip");
  AST_SKIP_NONZERO: assert property (
    exec_end && cur.op == bda_decrement_skip_nonzero_op &&
    fval != 8'h01 |=> state == bda_st_flush)
    else $error("nonzero result did not skip");
  AST_IDLE_OUT: assert property (
    state == bda_st_flush |-> idle_op && busy)
    else $error("idle cycle not flagged");
  AST_NO_SKIP_ONE: assert property (
    exec_end && !res_skip |=> state == bda_st_idle && cycles_last == 2'd1)
    else $error("non-skip took more than one cycle");
  AST_TWO_WORD: assert property (
    exec_end && res_skip && cur.two_word |=>
    (state == bda_st_flush)[*8] ##1 state == bda_st_idle)
    else $error("two-word skip length wrong");
  AST_ACCESS: assert property (
    state == bda_st_exec && !cur.bank_sel |->
    op_addr[7:0] == cur.faddr && (op_addr[11:8] == `BDA_ACC_LO_BANK ||
    op_addr[11:8] == `BDA_ACC_HI_BANK))
    else $error("quick-access address wrong");
  AST_KEEP_FLAGS: assert property (
    exec_end && cur.op[1] |=> flags == $past(flags))
    else $error("skip decrement changed flags");
endmodule
`default_nettype wire

// *** verilog/bda_dec_unit.sv ***
// combinational decimal adjust and decrement arithmetic
`include "bda_defs.svh"
`default_nettype none
module bda_dec_unit (
  input wire bda_pkg::bda_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] fval,
  input wire bda_pkg::bda_flags_t flags_in,
  output bda_pkg::bda_flags_t flags_out,
  output logic [7:0] result,
  output logic skip
);
  import bda_pkg::*;
  logic lo_adj;
  logic hi_adj;
  logic [8:0] mid;
  logic [8:0] adj;
  logic [7:0] dec;

  always_comb begin
    // low nibble correction
    // low nibble adjust
    lo_adj = (acc[3:0] > `BDA_BCD_MAX) | flags_in.half_carry_flag;
    mid = {1'b0, acc} + (lo_adj ? `BDA_ADJ_LO : 9'h000);
    hi_adj = (mid[7:4] > `BDA_BCD_MAX) | flags_in.carry_flag | mid[8];
    adj = mid + (hi_adj ? `BDA_ADJ_HI : 9'h000);
    dec = fval - 8'h01;
    flags_out = flags_in;
    result = dec;
    skip = 1'b0;
    unique case (op)
      bda_decimal_adjust_op: begin
        result = adj[7:0];
        flags_out.carry_flag = flags_in.carry_flag | adj[8] | mid[8];
      end
      bda_decrement_op: begin
        flags_out.carry_flag = (fval != 8'h00);
        flags_out.half_carry_flag = (fval[3:0] != 4'h0);
        flags_out.negative_flag = dec[7];
        flags_out.overflow_flag = (fval == `BDA_OVFL_EDGE);
        flags_out.zero_flag = (dec == 8'h00);
      end
      bda_decrement_skip_zero_op: begin
        skip = (dec == 8'h00);
      end
      bda_decrement_skip_nonzero_op: begin
        skip = (dec != 8'h00);
      end
    endcase
  end
endmodule
`default_nettype wire
